/* verilog/tcl_regs.sv */
// Register bank: calibration policy, flag clears, PWM assignment apply, static LED drive.
// Assumes writes arrive as one-cycle strobes from the serial slave engine on core_clk.
//
// Behaviour
// - LED/PWM writes 0xF9..0xFC start self-calibration unless inhibit bit set.
// - Periodic-calibration disable bit set stops periodic calibration.
// - Condition bit 1 runs always; 0 only while some LED lit.
// - Flash bit 1 ignores PWM ports; 0 needs PWM ports inactive.
// - While flashing, periodic needs disable 0 and flash bit 1.
// - Interval is five seconds times field plus one.
// - Writing 0 to interrupt clear bits clears init/soft/self/periodic flags.
// - Writing 0 clears press flag of sensor n.
// - Writing 0 clears release flag of sensor n.
// - Writing 0 clears long-touch flag of sensor n.
// - Writing 0 clears blink-done flag of timer n.
// - Writing 1 to apply bit makes staged LED timer selects active.
// - LED drive bits statically drive five LED ports high or low.
// - Finished timer sets its done flag and raises interrupt unless its bit is set in the mask taken at configuration apply.
// - Calibration policy acts only after configuration-apply bit written.
`timescale 1ns/10ps
`include "tcl_consts.svh"
module tcl_regs
  import tcl_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `TCL_INTERVAL_UNIT_S * `TCL_CLK_MHZ * 1000000
) (
  input wire logic core_clk, // System clock, 125 MHz
  input wire logic nrst, // Synchronous reset, low
  input wire tcl_wr_t wr, // Register write strobe
  input wire logic [7:0] rd_addr, // Read address
  input wire tcl_evt_t evt, // Flag set events
  input wire logic [3:0] blink_mask, // Staged done-interrupt mask
  input wire logic [4:0] pwm_flashing, // LED ports flashing by PWM
  output logic [7:0] rd_data_q, // Registered read data
  output logic [4:0] led_static_on_q, // Static LED port levels
  output logic [9:0] led_timer_select_q, // Active LED timer selects
  output logic self_cal_req_q, // Self-calibration request strobe
  output logic periodic_cal_req_q, // Periodic calibration request strobe
  output logic [4:0] int_flags_q, // Pending interrupt flags
  output logic [4:0] press_flags_q, // Switch-on flags
  output logic [4:0] release_flags_q, // Switch-off flags
  output logic [4:0] long_touch_flags_q, // Continuous touch flags
  output logic [3:0] blink_done_q, // PWM finish flags
  output logic irq_q // Interrupt output
);
  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  function automatic logic hit(input tcl_wr_t w, input logic [7:0] a);
    hit = w.we && (w.addr == a);
  endfunction : hit

  // Clear-flag update: set wins over the zero-written clear
  function automatic logic [4:0] upd(input logic [4:0] cur, input logic [4:0] set,
                                     input logic clr_en, input logic [4:0] wdat);
    upd = (cur & ~(clr_en ? ~wdat : 5'h0)) | set;
  endfunction : upd

  logic [7:0] staged_policy_q, policy_q;
  logic [9:0] staged_select_q;
  logic [3:0] active_mask_q;
  logic led_range_wr;
  tcl_cal_st_t cal_st_q;
  logic interval_fire;
  logic periodic_ok;

  assign led_range_wr = wr.we && (wr.addr >= `TCL_OFS_ASSIGN_APPLY) && (wr.addr <= `TCL_OFS_PWM_ENABLE);

  // ----------------------------------------
  // Staged configuration and apply
  // ----------------------------------------
  // Policy written to staging; becomes active only on configuration apply
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      staged_policy_q <= `TCL_RST_BYTE;
      policy_q <= `TCL_RST_BYTE;
      active_mask_q <= 4'h0;
    end else begin
      if (hit(wr, `TCL_OFS_CAL_POLICY)) begin
        staged_policy_q <= wr.data;
      end
      if (hit(wr, `TCL_OFS_FE_CTRL) && wr.data[`TCL_BIT_CFG_APPLY]) begin
        policy_q <= staged_policy_q;
        active_mask_q <= blink_mask;
      end
    end
  end

  // LED timer selects staged then applied by apply bit
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      staged_select_q <= 10'h0;
      led_timer_select_q <= 10'h0;
    end else begin
      if (hit(wr, `TCL_OFS_ASSIGN_LO)) begin
        staged_select_q[7:0] <= wr.data;
      end
      if (hit(wr, `TCL_OFS_ASSIGN_HI)) begin
        staged_select_q[9:8] <= wr.data[1:0];
      end
      if (hit(wr, `TCL_OFS_ASSIGN_APPLY) && wr.data[`TCL_BIT_ASSIGN_APPLY]) begin
        led_timer_select_q <= staged_select_q;
      end
    end
  end

  // Static LED drive
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      led_static_on_q <= 5'h0;
    end else if (hit(wr, `TCL_OFS_LED_DRIVE)) begin
      led_static_on_q <= wr.data[4:0];
    end
  end

  // ----------------------------------------
  // Calibration requests
  // ----------------------------------------
  // Self-calibration on LED/PWM writes unless inhibited
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      self_cal_req_q <= 1'b0;
    end else begin
      self_cal_req_q <= led_range_wr && !policy_q[`TCL_BIT_CALIB_INH];
    end
  end

  tcl_interval_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .period(policy_q[7:`TCL_POS_PERIOD]),
    .fire_q(interval_fire)
  );

  // Permission: disable blocks all; flashing needs flash bit; else LED-lit condition
  always_comb begin
    periodic_ok = !policy_q[`TCL_BIT_PER_DIS];
    if (|pwm_flashing && !policy_q[`TCL_BIT_PER_FLASH]) begin
      periodic_ok = 1'b0;
    end
    if (!policy_q[`TCL_BIT_PER_COND] && !(|led_static_on_q) && !(|pwm_flashing)) begin
      periodic_ok = 1'b0;
    end
  end

  // Request only at an interval expiry; a refused interval is skipped, not queued
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cal_st_q <= TCL_IDLE;
      periodic_cal_req_q <= 1'b0;
    end else begin
      case (cal_st_q)
        TCL_IDLE: begin
          periodic_cal_req_q <= 1'b0;
          if (interval_fire && periodic_ok) begin
            cal_st_q <= TCL_REQ;
          end
        end
        TCL_REQ: begin
          periodic_cal_req_q <= 1'b1;
          cal_st_q <= TCL_IDLE;
        end
        default: begin
          cal_st_q <= TCL_IDLE;
          periodic_cal_req_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pending flags and write-zero clears
  // ----------------------------------------
  // Interrupt flags; bit 3 position unused
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      int_flags_q <= 5'h0;
    end else begin
      int_flags_q <= upd(int_flags_q, evt.intr & 5'(`TCL_INT_FLAG_MASK),
                         hit(wr, `TCL_OFS_INT_CLR), wr.data[4:0] | 5'h08);
    end
  end

  // Sensor detection flags
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      press_flags_q <= 5'h0;
      release_flags_q <= 5'h0;
      long_touch_flags_q <= 5'h0;
    end else begin
      press_flags_q <= upd(press_flags_q, evt.press, hit(wr, `TCL_OFS_PRESS_CLR), wr.data[4:0]);
      release_flags_q <= upd(release_flags_q, evt.release_, hit(wr, `TCL_OFS_RELEASE_CLR),
                             wr.data[4:0]);
      long_touch_flags_q <= upd(long_touch_flags_q, evt.long_touch, hit(wr, `TCL_OFS_LONG_CLR),
                                wr.data[4:0]);
    end
  end

  // PWM finish flags, set wins
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      blink_done_q <= 4'h0;
    end else begin
      blink_done_q <= 4'(upd({1'b0, blink_done_q}, {1'b0, evt.blink_done}, hit(wr, `TCL_OFS_BLINK_CLR),
                             wr.data[4:0] | 5'h10));
    end
  end

  // Interrupt level follows unmasked pending flags, one cycle after them
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|int_flags_q) || (|(blink_done_q & ~active_mask_q));
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Clear registers read as zero; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_data_q <= `TCL_RST_BYTE;
    end else begin
      case (rd_addr)
        `TCL_OFS_CAL_POLICY: rd_data_q <= staged_policy_q;
        `TCL_OFS_ASSIGN_APPLY: rd_data_q <= `TCL_RST_BYTE;
        `TCL_OFS_LED_DRIVE: rd_data_q <= {3'h0, led_static_on_q};
        default: rd_data_q <= `TCL_RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_self_cal_req: assert property (@(posedge core_clk) disable iff (!nrst)
    led_range_wr |=> self_cal_req_q == !$past(policy_q[`TCL_BIT_CALIB_INH]))
    else $error("self calibration request mismatch");
  chk_disable_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
    (interval_fire && policy_q[`TCL_BIT_PER_DIS]) |=> ##1 !periodic_cal_req_q)
    else $error("periodic calibration while disabled");
  chk_flash_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
    (interval_fire && |pwm_flashing && !policy_q[`TCL_BIT_PER_FLASH]) |=> ##1 !periodic_cal_req_q)
    else $error("periodic calibration while flashing");
  chk_cond_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
    (interval_fire && !periodic_ok) |-> ##2 !periodic_cal_req_q)
    else $error("periodic calibration without permission");
  chk_press_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    (hit(wr, `TCL_OFS_PRESS_CLR) && !wr.data[0] && !evt.press[0]) |=> !press_flags_q[0])
    else $error("press flag not cleared");
  chk_set_wins: assert property (@(posedge core_clk) disable iff (!nrst)
    evt.blink_done[0] |=> blink_done_q[0])
    else $error("blink done flag lost");
  chk_led_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    hit(wr, `TCL_OFS_LED_DRIVE) |=> led_static_on_q == $past(wr.data[4:0]))
    else $error("led drive not updated");
  chk_apply_select: assert property (@(posedge core_clk) disable iff (!nrst)
    (hit(wr, `TCL_OFS_ASSIGN_APPLY) && wr.data[0]) |=> led_timer_select_q == $past(staged_select_q))
    else $error("timer select not applied");
  chk_irq_level: assert property (@(posedge core_clk) disable iff (!nrst)
    (|int_flags_q) |=> irq_q)
    else $error("interrupt not raised");
  // Clear, hold, grant and interrupt checks
  // A zero bit clears, a one bit keeps; staged fields wait for their apply strobe
  chk_int_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    (hit(wr, `TCL_OFS_INT_CLR) && !wr.data[`TCL_BIT_SELF] && !evt.intr[`TCL_BIT_SELF]) |=> !int_flags_q[`TCL_BIT_SELF])
    else $error("self calibration flag not cleared");
  chk_release_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    (hit(wr, `TCL_OFS_RELEASE_CLR) && !wr.data[4] && !evt.release_[4]) |=> !release_flags_q[4])
    else $error("release flag not cleared");
  chk_long_keep: assert property (@(posedge core_clk) disable iff (!nrst)
    (hit(wr, `TCL_OFS_LONG_CLR) && wr.data[1] && long_touch_flags_q[1]) |=> long_touch_flags_q[1])
    else $error("long touch flag lost on one bit");
  chk_policy_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    hit(wr, `TCL_OFS_CAL_POLICY) |=> policy_q == $past(policy_q))
    else $error("policy changed without apply");
  chk_select_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (hit(wr, `TCL_OFS_ASSIGN_LO) || hit(wr, `TCL_OFS_ASSIGN_HI)) |=> led_timer_select_q == $past(led_timer_select_q))
    else $error("timer select changed without apply");
  chk_periodic_grant: assert property (@(posedge core_clk) disable iff (!nrst)
    (interval_fire && periodic_ok) |-> ##2 periodic_cal_req_q)
    else $error("permitted periodic calibration missing");
  chk_blink_irq: assert property (@(posedge core_clk) disable iff (!nrst)
    (|(blink_done_q & ~active_mask_q)) |=> irq_q)
    else $error("finish flag raised no interrupt");
  chk_irq_release: assert property (@(posedge core_clk) disable iff (!nrst)
    (int_flags_q == 5'h00 && blink_done_q == 4'h0) |=> !irq_q)
    else $error("interrupt held without flags");
endmodule : tcl_regs

/* verilog/tcl_consts.svh */
// Constants of the touch calibration / LED register block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and modules.
`ifndef TCL_CONSTS_SVH
`define TCL_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TCL_OFS_ASSIGN_LO 8'hed
`define TCL_OFS_ASSIGN_HI 8'hee
`define TCL_OFS_CAL_POLICY 8'hef
`define TCL_OFS_INT_CLR 8'hf0
`define TCL_OFS_PRESS_CLR 8'hf1
`define TCL_OFS_RELEASE_CLR 8'hf2
`define TCL_OFS_LONG_CLR 8'hf3
`define TCL_OFS_BLINK_CLR 8'hf4
`define TCL_OFS_ASSIGN_APPLY 8'hf9
`define TCL_OFS_LED_DRIVE 8'hfa
`define TCL_OFS_PWM_SELECT 8'hfb
`define TCL_OFS_PWM_ENABLE 8'hfc
`define TCL_OFS_FE_CTRL 8'hff
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCL_BIT_CALIB_INH 0
`define TCL_BIT_PER_DIS 1
`define TCL_BIT_PER_COND 2
`define TCL_BIT_PER_FLASH 3
`define TCL_POS_PERIOD 4
`define TCL_BIT_INIT 0
`define TCL_BIT_SOFT 1
`define TCL_BIT_SELF 2
`define TCL_BIT_PERIODIC 4
`define TCL_BIT_CFG_APPLY 2
`define TCL_BIT_ASSIGN_APPLY 0
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TCL_RST_BYTE 8'h00
`define TCL_INT_FLAG_MASK 8'h17
`define TCL_CLK_MHZ 125
`define TCL_INTERVAL_UNIT_S 5
`endif

/* verilog/tcl_pkg.sv */
// Types of the touch calibration / LED register block.
// Assumes tcl_consts.svh on the include path.
package tcl_pkg;
  `include "tcl_consts.svh"
  // Register write strobe from the serial slave engine
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } tcl_wr_t;
  // Flag events raised by the sensing and PWM engines
  typedef struct packed {
    logic [4:0] intr;
    logic [4:0] press;
    logic [4:0] release_;
    logic [4:0] long_touch;
    logic [3:0] blink_done;
  } tcl_evt_t;
  typedef enum logic [1:0] {
    TCL_IDLE = 2'b00,
    TCL_REQ = 2'b01
  } tcl_cal_st_t;
endpackage : tcl_pkg

/* verilog/tcl_interval_timer.sv */
// Periodic calibration interval timer: ticks every unit, fires after (period+1) units.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/10ps
module tcl_interval_timer #(
  parameter int unsigned UNIT_CYCLES = 625000000
) (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Synchronous reset, low
  input wire logic [3:0] period, // Interval field
  output logic fire_q // One-cycle interval expiry
);
  // A unit shorter than two cycles leaves the prescaler no usable compare value
  if (UNIT_CYCLES < 2) begin : g_bad_unit
    $error("UNIT_CYCLES too small");
  end
  logic [31:0] unit_q;
  logic [4:0] units_q;
  // Unit prescaler and unit counter; field change takes effect at the next unit boundary, within the current interval
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      unit_q <= 32'h0;
      units_q <= 5'h0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      if (unit_q == UNIT_CYCLES - 1) begin
        unit_q <= 32'h0;
        if (units_q >= {1'b0, period}) begin
          units_q <= 5'h0;
          fire_q <= 1'b1;
        end else begin
          units_q <= units_q + 5'h1;
        end
      end else begin
        unit_q <= unit_q + 32'h1;
      end
    end
  end
endmodule : tcl_interval_timer

/* testbench/tcl_host_model.sv */
// Host-side model of the serial slave engine: register write strobes and reads.
// Assumes the bench calls its tasks from one process, on core_clk.
`timescale 1ns/10ps
module tcl_host_model
  import tcl_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = 81250
) (
  input wire logic core_clk, // System clock
  input wire logic [7:0] rd_data_q, // Registered read data
  output tcl_wr_t wr, // Write strobe to the bank
  output logic [7:0] rd_addr // Read address
);
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  initial begin
    wr = '0;
    rd_addr = 8'h00;
  end
  // Waits out the spacing first so the caller can check right after return
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    repeat (GAP_CYCLES) @(posedge core_clk);
    wr <= '{we: 1'b1, addr: addr, data: data};
    @(posedge core_clk);
    wr <= '{we: 1'b0, addr: ~addr, data: ~data}; // Released lines show stale-free junk
  endtask : write_reg
  // Address held two edges, data taken once settled
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    rd_addr <= addr;
    repeat (2) @(posedge core_clk);
    #1 data = rd_data_q;
  endtask : read_reg
endmodule : tcl_host_model

/* testbench/testbench.sv */
// Self-checking bench of the register bank: rows for plain writes, hand tests after.
// Assumes tcl_regs with a shortened interval unit and the host model beside it.
`timescale 1ns/10ps
module testbench;
  import tcl_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [4:0] led;
    logic self_cal;
  } tcl_row_t;
  logic core_clk, nrst;
  tcl_wr_t wr;
  tcl_evt_t evt;
  logic [7:0] rd_addr, rd_data_q, rdv;
  logic [4:0] pwm_flashing, led_q, int_f, press_f, rel_f, long_f;
  logic [9:0] sel_q;
  logic [3:0] blink_f, blink_mask;
  logic self_q, per_q, irq_q;
  int bad_count, check_count, self_n, per_n;
  tcl_row_t rows[8] = '{'{8'hfa, 8'h03, 5'h03, 1'b1}, '{8'hfa, 8'h1f, 5'h1f, 1'b1}, '{8'hfb, 8'h00, 5'h1f, 1'b1},
    '{8'hfc, 8'h00, 5'h1f, 1'b1}, '{8'hf9, 8'h00, 5'h1f, 1'b1}, '{8'hf0, 8'hff, 5'h1f, 1'b0},
    '{8'hf8, 8'h00, 5'h1f, 1'b0}, '{8'hfe, 8'h00, 5'h1f, 1'b0}};
  // ----------------------------------------
  // Clock, parts
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  tcl_regs #(.UNIT_CYCLES(4)) uut (.core_clk(core_clk), .nrst(nrst), .wr(wr), .rd_addr(rd_addr), .evt(evt),
    .blink_mask(blink_mask), .pwm_flashing(pwm_flashing), .rd_data_q(rd_data_q), .led_static_on_q(led_q),
    .led_timer_select_q(sel_q), .self_cal_req_q(self_q), .periodic_cal_req_q(per_q), .int_flags_q(int_f),
    .press_flags_q(press_f), .release_flags_q(rel_f), .long_touch_flags_q(long_f), .blink_done_q(blink_f),
    .irq_q(irq_q));
  // Short spacing keeps the run brief; the logic has no spacing of its own
  tcl_host_model #(.GAP_CYCLES(4)) host (.core_clk(core_clk), .rd_data_q(rd_data_q), .wr(wr), .rd_addr(rd_addr));
  // Request counters, cleared by the bench one step after an edge
  always @(posedge core_clk) begin
    if (self_q === 1'b1) self_n++;
    if (per_q === 1'b1) per_n++;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Write, then look one edge later
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
    #1 self_n = 0;
    host.write_reg(a, d);
    @(posedge core_clk);
    #1;
  endtask : wr_chk
  task automatic count_per(input int cycles, input int lo, input int hi);
    // Let a request granted under the old permission land before counting
    repeat (3) @(posedge core_clk);
    #1 per_n = 0;
    repeat (cycles) @(posedge core_clk);
    #1 check_count++;
    if (per_n < lo || per_n > hi) begin
      bad_count++;
      $display("ERROR periodic requests expected %0d..%0d seen %0d", lo, hi, per_n);
    end
  endtask : count_per
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    evt = '0;
    pwm_flashing = 5'h00;
    blink_mask = 4'h0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    #1 chk("led reset", 16'h0000, {11'h000, led_q});
    chk("irq reset", 16'h0000, {15'h0000, irq_q});
    for (int i = 0; i < 8; i++) begin
      wr_chk(rows[i].addr, rows[i].data);
      chk("led level", {11'h000, rows[i].led}, {11'h000, led_q});
      chk("self cal", {15'h0000, rows[i].self_cal}, 16'(self_n));
    end
    host.read_reg(8'hfa, rdv);
    chk("led read", 16'h001f, {8'h00, rdv});
    // Staged policy has no effect until applied
    wr_chk(8'hef, 8'h01);
    wr_chk(8'hfa, 8'h1f);
    chk("self cal staged", 16'h0001, 16'(self_n));
    host.read_reg(8'hef, rdv);
    chk("policy read", 16'h0001, {8'h00, rdv});
    wr_chk(8'hff, 8'h04);
    wr_chk(8'hfb, 8'h00);
    chk("self cal inhibit", 16'h0000, 16'(self_n));
    // Assignment apply
    wr_chk(8'hed, 8'he4);
    wr_chk(8'hee, 8'h01);
    chk("select staged", 16'h0000, {6'h00, sel_q});
    wr_chk(8'hf9, 8'h01);
    chk("select applied", 16'h01e4, {6'h00, sel_q});
    // Flags set, partly cleared with zero bits, then fully cleared
    @(posedge core_clk);
    evt <= '1;
    @(posedge core_clk);
    evt <= '0;
    repeat (2) @(posedge core_clk);
    #1 chk("int set", 16'h0017, {11'h000, int_f});
    chk("blink set", 16'h000f, {12'h000, blink_f});
    chk("irq set", 16'h0001, {15'h0000, irq_q});
    for (int a = 8'hf0; a <= 8'hf4; a++) wr_chk(8'(a), 8'hfa);
    chk("int part", 16'h0012, {11'h000, int_f});
    chk("press part", 16'h001a, {11'h000, press_f});
    chk("release part", 16'h001a, {11'h000, rel_f});
    chk("long part", 16'h001a, {11'h000, long_f});
    chk("blink part", 16'h000a, {12'h000, blink_f});
    chk("irq held", 16'h0001, {15'h0000, irq_q});
    for (int a = 8'hf0; a <= 8'hf4; a++) wr_chk(8'(a), 8'h00);
    chk("all flags", 16'h0000, {int_f, press_f, rel_f, long_f[0]});
    chk("irq clear", 16'h0000, {blink_f, long_f[4:1], 7'h00, irq_q});
    // Periodic: LEDs lit, condition 0, interval one unit
    count_per(40, 9, 11);
    wr_chk(8'hef, 8'h03);
    wr_chk(8'hff, 8'h04);
    count_per(40, 0, 0);
    wr_chk(8'hfa, 8'h00);
    wr_chk(8'hef, 8'h01);
    wr_chk(8'hff, 8'h04);
    count_per(40, 0, 0);
    wr_chk(8'hef, 8'h05);
    wr_chk(8'hff, 8'h04);
    count_per(40, 9, 11);
    pwm_flashing <= 5'h01;
    count_per(40, 0, 0);
    wr_chk(8'hef, 8'h0d);
    wr_chk(8'hff, 8'h04);
    count_per(40, 9, 11);
    wr_chk(8'hef, 8'h0f);
    wr_chk(8'hff, 8'h04);
    count_per(40, 0, 0);
    pwm_flashing <= 5'h00;
    wr_chk(8'hef, 8'hf5);
    wr_chk(8'hff, 8'h04);
    count_per(160, 2, 3);
    // Mid-run reset: applied selects and staged policy return to rest
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    #1 chk("select reset", 16'h0000, {6'h00, sel_q});
    host.read_reg(8'hef, rdv);
    chk("policy reset", 16'h0000, {8'h00, rdv});
    wr_chk(8'hfa, 8'h01);
    chk("self cal reset", 16'h0001, 16'(self_n));
    // Masked finish flag is kept but raises no interrupt
    blink_mask <= 4'h1;
    wr_chk(8'hff, 8'h04);
    evt.blink_done <= 4'h1;
    @(posedge core_clk);
    evt.blink_done <= 4'h0;
    repeat (2) @(posedge core_clk);
    #1 chk("blink masked", 16'h0001, {12'h000, blink_f});
    chk("irq masked", 16'h0000, {15'h0000, irq_q});
    report_and_stop();
  end
endmodule : testbench
